// [include/accel_regs_pkg.sv]
// constants, register map and state encodings for the accelerometer
// readout register block; assumes a 40 MHz system clock
package accel_regs_pkg;

    // -------------------------------------------------------------
    // clock and timing
    // -------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    // deep-sleep entry delay after chip select rises (typical figure)
    localparam int SLEEP_DELAY_NS = 1000;
    localparam int SLEEP_DELAY_CYC = (SLEEP_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     SLEEP_DELAY_NS / CLK_PERIOD_NS;
    // wake deglitch filter, a least time so rounded up
    localparam int WAKE_DEGLITCH_NS = 10000;
    localparam int WAKE_DEGLITCH_CYC = (WAKE_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // boot-complete pulse length
    localparam int BOOT_PULSE_NS = 100000;
    localparam int BOOT_PULSE_CYC = BOOT_PULSE_NS / CLK_PERIOD_NS;
    // internal boot sequence length before the pulse
    localparam int BOOT_SEQ_CYC = 16;
    localparam int TIMER_W = 16;

    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam logic [6:0] ADDR_EVENT_FLAGS = 7'h00;
    localparam logic [6:0] ADDR_TEMPERATURE = 7'h01;
    localparam logic [6:0] ADDR_MAG_FIRST = 7'h02;
    localparam logic [6:0] ADDR_MAG_SECOND = 7'h03;
    localparam logic [6:0] ADDR_X_FIRST = 7'h04;
    localparam logic [6:0] ADDR_X_SECOND = 7'h05;
    localparam logic [6:0] ADDR_Y_FIRST = 7'h06;
    localparam logic [6:0] ADDR_Y_SECOND = 7'h07;
    localparam logic [6:0] ADDR_PAST_Y = 7'h08;
    localparam logic [6:0] ADDR_CFG_A = 7'h15;
    localparam logic [6:0] ADDR_CFG_B = 7'h16;
    localparam logic [6:0] ADDR_CFG_E = 7'h19;

    localparam logic [7:0] EVENT_FLAGS_RST = 8'h01;
    localparam logic [7:0] CFG_RST = 8'h00;

    // sensor_config_a fields
    localparam int CFG_A_ACTIVE = 0;
    // sensor_config_b fields
    localparam int CFG_B_BYTE_ORDER = 0;
    localparam int CFG_B_TEMP_IN_BURST = 1;
    localparam int CFG_B_FAST_READ = 2;
    // sensor_config_e fields
    localparam int CFG_E_DEEP_SLEEP = 0;
    localparam int CFG_E_MAG_ENABLE = 1;
    localparam int CFG_E_X_DISABLE = 2;
    localparam int CFG_E_Y_DISABLE = 3;

    // serial command byte: read flag in the top bit, address below
    localparam int CMD_READ_BIT = 7;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // -------------------------------------------------------------
    // power states
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_BOOT       = 3'b000,
        ST_BOOT_PULSE = 3'b001,
        ST_STANDBY    = 3'b010,
        ST_ACTIVE     = 3'b011,
        ST_SLEEP_WAIT = 3'b100,
        ST_DEEP_SLEEP = 3'b101
    } power_state_t;

endpackage

// [hdl/pin_sync.sv]
// two-flop synchroniser for a group of independent pin levels
// assumes each bit is a slow level; no bus coherence is implied
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_reg;

    // -------------------------------------------------------------
    // first stage is read only by the second stage
    // -------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_reg <= RESET_VALUE;
            o_sync <= RESET_VALUE;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end

endmodule
`default_nettype wire

// [hdl/accel_readout_regs.sv]
// accelerometer readout registers, power-mode sequencing and serial port
// assumes serial pins come from the host asynchronously and sample data
// arrives on the system clock from the measurement path
`timescale 1ns/1ps
`default_nettype none
module accel_readout_regs
    import accel_regs_pkg::*;
#(
    parameter int BOOT_PULSE_CYCLES = BOOT_PULSE_CYC,
    parameter int WAKE_FILTER_CYCLES = WAKE_DEGLITCH_CYC,
    parameter int SLEEP_CYCLES = SLEEP_DELAY_CYC,
    parameter int BOOT_CYCLES = BOOT_SEQ_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sclk,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    output logic o_spi_miso_oe,
    input wire logic i_sample_valid,
    input wire logic [7:0] i_temp_data,
    input wire logic [11:0] i_vector_magnitude,
    input wire logic [11:0] i_x_data,
    input wire logic [11:0] i_y_data,
    input wire logic i_flags_valid,
    input wire logic [7:0] i_event_flags,
    output logic o_boot_pulse,
    output logic o_active,
    output logic o_deep_sleep
);

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        power_state_t st;
        logic [TIMER_W-1:0] timer;
        logic boot_pulse;
        logic active;
        logic deep_sleep;
        logic sleep_req;
        logic wake_ref;
        logic [7:0] cfg_a;
        logic [7:0] cfg_b;
        logic [7:0] cfg_e;
        logic [7:0] flags;
        logic [7:0] temp;
        logic [11:0] mag;
        logic [11:0] xd;
        logic [11:0] yd;
        logic sclk_prev;
        logic cs_prev;
        logic [2:0] bit_cnt;
        logic first_byte;
        logic is_read;
        logic [ADDR_W-1:0] ptr;
        logic [7:0] shin;
        logic [7:0] tx;
        logic miso;
        logic miso_oe;
    } state_t;

    state_t r_reg;
    state_t r_next;
    logic [2:0] pins_s;
    logic cs_s;
    logic sclk_s;
    logic mosi_s;

    // cs idles high, so it resets high to avoid a false frame start
    pin_sync #(
        .WIDTH(3),
        .RESET_VALUE(3'h4)
    ) u_pin_sync (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_async({i_spi_cs_n, i_spi_sclk, i_spi_mosi}),
        .o_sync(pins_s)
    );
    assign cs_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign mosi_s = pins_s[0];

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // pick one byte of a 12-bit value by byte order
    function automatic logic [7:0] split_byte(input logic [11:0] v, input logic be,
                                              input logic second);
        logic [7:0] b;
        b = 8'h00;
        if (!be) begin
            b = second ? {4'h0, v[11:8]} : v[7:0];
        end else begin
            b = second ? {4'h0, v[3:0]} : v[11:4];
        end
        return b;
    endfunction

    function automatic logic [7:0] read_byte(input logic [ADDR_W-1:0] a, input state_t s);
        logic be;
        logic [7:0] d;
        be = s.cfg_b[CFG_B_BYTE_ORDER];
        d = 8'h00;
        unique case (a)
            ADDR_EVENT_FLAGS: d = s.flags;
            ADDR_TEMPERATURE: d = s.temp;
            ADDR_MAG_FIRST: d = split_byte(s.mag, be, 1'b0);
            ADDR_MAG_SECOND: d = split_byte(s.mag, be, 1'b1);
            ADDR_X_FIRST: d = split_byte(s.xd, be, 1'b0);
            ADDR_X_SECOND: d = split_byte(s.xd, be, 1'b1);
            ADDR_Y_FIRST: d = split_byte(s.yd, be, 1'b0);
            ADDR_Y_SECOND: d = split_byte(s.yd, be, 1'b1);
            ADDR_CFG_A: d = s.cfg_a;
            ADDR_CFG_B: d = s.cfg_b;
            ADDR_CFG_E: d = s.cfg_e;
            default: d = 8'h00; // unmapped reads as zero
        endcase
        return d;
    endfunction

    // auto-increment pointer with skipping of disabled registers
    function automatic logic [ADDR_W-1:0] next_ptr(input logic [ADDR_W-1:0] a,
                                                   input state_t s);
        logic [ADDR_W-1:0] n;
        n = a + 7'h01;
        if (s.cfg_b[CFG_B_FAST_READ] && a == ADDR_X_FIRST) begin
            n = ADDR_Y_FIRST;
        end else if (s.cfg_b[CFG_B_FAST_READ] && a == ADDR_Y_FIRST) begin
            n = ADDR_PAST_Y;
        end else if (s.cfg_b[CFG_B_FAST_READ] && a == ADDR_PAST_Y) begin
            n = ADDR_EVENT_FLAGS;
        end else begin
            // chained so several skipped groups in a row fall through
            if (n == ADDR_TEMPERATURE && !s.cfg_b[CFG_B_TEMP_IN_BURST]) begin
                n = ADDR_MAG_FIRST;
            end
            // a group is skipped only when stepped into at its first byte
            if (n == ADDR_MAG_FIRST && !s.cfg_e[CFG_E_MAG_ENABLE]) begin
                n = ADDR_X_FIRST;
            end
            if (n == ADDR_X_FIRST && s.cfg_e[CFG_E_X_DISABLE]) begin
                n = ADDR_Y_FIRST;
            end
            if (n == ADDR_Y_FIRST && s.cfg_e[CFG_E_Y_DISABLE]) begin
                n = ADDR_PAST_Y;
            end
        end
        return n;
    endfunction

    // -------------------------------------------------------------
    // next-state logic
    // -------------------------------------------------------------
    always_comb begin
        logic sclk_rise;
        logic sclk_fall;
        logic cs_rise;
        logic serving;
        logic [7:0] b;
        logic [ADDR_W-1:0] np;
        sclk_rise = sclk_s & ~r_reg.sclk_prev;
        sclk_fall = ~sclk_s & r_reg.sclk_prev;
        cs_rise = cs_s & ~r_reg.cs_prev;
        serving = (r_reg.st == ST_STANDBY) || (r_reg.st == ST_ACTIVE);
        b = {r_reg.shin[6:0], mosi_s};
        np = next_ptr(r_reg.ptr, r_reg);
        r_next = r_reg;
        r_next.sclk_prev = sclk_s;
        r_next.cs_prev = cs_s;

        // latest completed sample, never disturbed by reads
        if (i_sample_valid) begin
            r_next.temp = i_temp_data;
            r_next.mag = i_vector_magnitude;
            r_next.xd = i_x_data;
            r_next.yd = i_y_data;
        end
        if (i_flags_valid) begin
            r_next.flags = i_event_flags;
        end

        // serial frame engine, idle outside standby and active
        if (!serving || cs_s) begin
            r_next.bit_cnt = 3'h0;
            r_next.first_byte = 1'b1;
            r_next.is_read = 1'b0;
            r_next.miso_oe = 1'b0;
            r_next.miso = 1'b0;
            r_next.tx = 8'h00;
        end else begin
            if (sclk_rise) begin
                r_next.shin = b;
                r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
                if (r_reg.bit_cnt == LAST_BIT) begin
                    r_next.first_byte = 1'b0;
                    if (r_reg.first_byte) begin
                        r_next.is_read = b[CMD_READ_BIT];
                        r_next.ptr = b[ADDR_W-1:0];
                        r_next.miso_oe = b[CMD_READ_BIT];
                        r_next.tx = b[CMD_READ_BIT] ? read_byte(b[ADDR_W-1:0], r_reg) : 8'h00;
                    end else if (r_reg.is_read) begin
                        r_next.ptr = np;
                        r_next.tx = read_byte(np, r_reg);
                    end else begin
                        r_next.ptr = r_reg.ptr + 7'h01;
                        unique case (r_reg.ptr)
                            ADDR_CFG_A: r_next.cfg_a = b;
                            ADDR_CFG_B: r_next.cfg_b = b;
                            ADDR_CFG_E: begin
                                r_next.cfg_e = b;
                                r_next.sleep_req = b[CFG_E_DEEP_SLEEP];
                            end
                            default: ; // output registers ignore writes
                        endcase
                    end
                end
            end
            if (sclk_fall) begin
                r_next.miso = r_reg.tx[7];
                r_next.tx = {r_reg.tx[6:0], 1'b0};
            end
        end

        // power-mode sequencer
        unique case (r_reg.st)
            ST_BOOT: begin
                r_next.timer = r_reg.timer - 16'h0001;
                if (r_reg.timer == '0) begin
                    r_next.st = ST_BOOT_PULSE;
                    r_next.boot_pulse = 1'b1;
                    r_next.timer = TIMER_W'(BOOT_PULSE_CYCLES - 1);
                end
            end
            ST_BOOT_PULSE: begin
                r_next.timer = r_reg.timer - 16'h0001;
                if (r_reg.timer == '0) begin
                    r_next.st = ST_STANDBY;
                    r_next.boot_pulse = 1'b0;
                end
            end
            ST_STANDBY, ST_ACTIVE: begin
                if (cs_rise && r_reg.sleep_req) begin
                    r_next.st = ST_SLEEP_WAIT;
                    r_next.sleep_req = 1'b0;
                    r_next.timer = TIMER_W'(SLEEP_CYCLES - 1);
                end else if (r_reg.cfg_a[CFG_A_ACTIVE]) begin
                    r_next.st = ST_ACTIVE;
                end else begin
                    r_next.st = ST_STANDBY;
                end
            end
            ST_SLEEP_WAIT: begin
                r_next.timer = r_reg.timer - 16'h0001;
                if (r_reg.timer == '0) begin
                    r_next.st = ST_DEEP_SLEEP;
                    r_next.wake_ref = cs_s;
                    r_next.timer = '0;
                end
            end
            ST_DEEP_SLEEP: begin
                // a glitch shorter than the filter restarts the count
                if (cs_s != r_reg.wake_ref) begin
                    r_next.timer = r_reg.timer + 16'h0001;
                    if (r_reg.timer == TIMER_W'(WAKE_FILTER_CYCLES - 1)) begin
                        r_next.st = ST_BOOT;
                        r_next.timer = TIMER_W'(BOOT_CYCLES - 1);
                        r_next.cfg_a = CFG_RST;
                        r_next.cfg_b = CFG_RST;
                        r_next.cfg_e = CFG_RST;
                    end
                end else begin
                    r_next.timer = '0;
                end
            end
            default: begin
                r_next.st = ST_BOOT;
                r_next.timer = TIMER_W'(BOOT_CYCLES - 1);
            end
        endcase
        r_next.active = (r_next.st == ST_ACTIVE);
        r_next.deep_sleep = (r_next.st == ST_DEEP_SLEEP);
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            r_reg <= '0;
            r_reg.st <= ST_BOOT;
            r_reg.timer <= TIMER_W'(BOOT_CYCLES - 1);
            r_reg.flags <= EVENT_FLAGS_RST;
            r_reg.cfg_a <= CFG_RST;
            r_reg.cfg_b <= CFG_RST;
            r_reg.cfg_e <= CFG_RST;
            r_reg.sclk_prev <= 1'b0;
            r_reg.cs_prev <= 1'b1;
            r_reg.first_byte <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_spi_miso = r_reg.miso;
    assign o_spi_miso_oe = r_reg.miso_oe;
    assign o_boot_pulse = r_reg.boot_pulse;
    assign o_active = r_reg.active;
    assign o_deep_sleep = r_reg.deep_sleep;

endmodule
`default_nettype wire

// [tb/accel_checker.sv]
// concurrent checks on the power-mode outputs and the miso enable of the readout block
// assumes it is bound into accel_readout_regs and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module accel_checker #(
    parameter int BOOT_PULSE_CYCLES = 8,
    parameter int WAKE_FILTER_CYCLES = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_spi_cs_n,
    input wire logic o_spi_miso_oe,
    input wire logic o_boot_pulse,
    input wire logic o_active,
    input wire logic o_deep_sleep
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    logic [15:0] pulse_cnt;
    logic [15:0] cs_still;
    logic cs_prev;
    // pulse length so far, and how long the raw cs pin has held its level
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pulse_cnt <= '0;
            cs_still <= '0;
            cs_prev <= 1'b1;
        end else begin
            pulse_cnt <= o_boot_pulse ? pulse_cnt + 16'h0001 : 16'h0000;
            // saturate so a long idle cs never wraps to a false short count
            cs_still <= (i_spi_cs_n != cs_prev) ? 16'h0000 :
                        (cs_still == 16'hffff) ? cs_still : cs_still + 16'h0001;
            cs_prev <= i_spi_cs_n;
        end
    end
    pulse_len_a: assert property (
        $fell(o_boot_pulse) |-> pulse_cnt == 16'(BOOT_PULSE_CYCLES))
        else $error("boot pulse length wrong");
    pulse_max_a: assert property (
        o_boot_pulse |-> pulse_cnt < 16'(BOOT_PULSE_CYCLES))
        else $error("boot pulse too long");
    boot_quiet_a: assert property (
        o_boot_pulse |-> !o_active && !o_deep_sleep)
        else $error("mode set during boot pulse");
    sleep_after_cs_a: assert property (
        $rose(o_deep_sleep) |-> i_spi_cs_n && cs_still >= 16'h001e)
        else $error("deep sleep entered too soon after cs rise");
    wake_filter_a: assert property (
        $fell(o_deep_sleep) |-> cs_still >= 16'(WAKE_FILTER_CYCLES))
        else $error("wake on a short cs change");
    sleep_silent_a: assert property (
        o_deep_sleep |-> !o_spi_miso_oe && !o_active)
        else $error("activity in deep sleep");
    active_from_standby_a: assert property (
        $rose(o_active) |-> !$past(o_boot_pulse) && !$past(o_deep_sleep))
        else $error("active entered outside standby");
    oe_idle_a: assert property (
        i_spi_cs_n [*6] |=> !o_spi_miso_oe)
        else $error("miso driven with cs high");
endmodule
bind accel_readout_regs accel_checker #(
    .BOOT_PULSE_CYCLES(BOOT_PULSE_CYCLES),
    .WAKE_FILTER_CYCLES(WAKE_FILTER_CYCLES)
) i_chk (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_spi_cs_n(i_spi_cs_n),
    .o_spi_miso_oe(o_spi_miso_oe),
    .o_boot_pulse(o_boot_pulse),
    .o_active(o_active),
    .o_deep_sleep(o_deep_sleep)
);
`default_nettype wire

// [tb/spi_host.sv]
// host controller model: mode 0 serial frames and the wake toggle
// assumes frames are started only once the device has left boot
`timescale 1ns/1ps
`default_nettype none
module spi_host (
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_mosi,
    input wire logic i_miso,
    output logic o_rd_strobe,
    output logic [7:0] o_rd_byte
);
    // idle pins; sclk stands low between frames
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_mosi = 1'b0;
        o_rd_strobe = 1'b0;
        o_rd_byte = 8'h00;
    end
    // one byte each way msb first, 200 ns per bit; miso taken at the rise
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_mosi = tx[i];
            #100 o_sclk = 1'b1;
            rx[i] = i_miso;
            #100 o_sclk = 1'b0;
        end
    endtask
    // command byte, then n data bytes; each read byte is reported by a strobe
    task automatic frame(input logic [7:0] cmd, input int n, input logic [7:0] wdat);
        logic [7:0] rx;
        o_cs_n = 1'b0;
        #100 shift(cmd, rx);
        for (int k = 0; k < n; k++) begin
            shift(wdat, rx);
            o_rd_byte = rx;
            o_rd_strobe = cmd[7];
            #1 o_rd_strobe = 1'b0;
        end
        #99 o_cs_n = 1'b1;
        o_mosi = ~o_mosi; // deselected: no stale level left on the line
        #200;
    endtask
    // cs pulled low for a while: short ones must be filtered out
    task automatic wake(input int ns);
        o_cs_n = 1'b0;
        #ns o_cs_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the accelerometer readout register block
// assumes shortened boot and wake counts; expected bytes queue to a monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
    import accel_regs_pkg::*;
    localparam int BPC = 8;
    logic clk_sys, sys_rst, sample_valid, flags_valid;
    logic cs_n, sclk, mosi, miso, miso_oe, rd_strobe, boot_pulse, active, deep_sleep;
    logic bo, tib, fr, me, xdis, ydis;
    logic [7:0] temp, flags, rd_byte;
    logic [11:0] mag, xd, yd;
    logic [31:0] seed;
    logic [7:0] exp_q[$];
    int failures, cmp_count, cycles;

    accel_readout_regs #(.BOOT_PULSE_CYCLES(BPC), .WAKE_FILTER_CYCLES(4),
        .SLEEP_CYCLES(40), .BOOT_CYCLES(16)) i_dut (
        .i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_spi_cs_n(cs_n), .i_spi_sclk(sclk),
        .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe),
        .i_sample_valid(sample_valid), .i_temp_data(temp), .i_vector_magnitude(mag),
        .i_x_data(xd), .i_y_data(yd), .i_flags_valid(flags_valid), .i_event_flags(flags),
        .o_boot_pulse(boot_pulse), .o_active(active), .o_deep_sleep(deep_sleep));
    // a released miso line shows the inverse, so an early release corrupts the read
    spi_host i_host (.o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi),
        .i_miso(miso_oe ? miso : ~miso),
        .o_rd_strobe(rd_strobe), .o_rd_byte(rd_byte));

    // 40 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic step();
        @(posedge clk_sys);
        #2;
    endtask
    // byte split of a 12-bit value by byte order
    function automatic logic [7:0] split(input logic [11:0] v, input logic second);
        if (!bo) return second ? {4'h0, v[11:8]} : v[7:0];
        return second ? {4'h0, v[3:0]} : v[11:4];
    endfunction
    function automatic logic [7:0] val(input logic [6:0] a);
        case (a)
            7'h00: return flags;
            7'h01: return temp;
            7'h02, 7'h03: return split(mag, a[0]);
            7'h04, 7'h05: return split(xd, a[0]);
            7'h06, 7'h07: return split(yd, a[0]);
            default: return 8'h00;
        endcase
    endfunction
    // pointer step with skipping of disabled registers
    function automatic logic [6:0] nxt(input logic [6:0] a);
        if (fr && a == 7'h04) return 7'h06;
        if (fr && a == 7'h06) return 7'h08;
        if (a == 7'h08) return 7'h00;
        if (a == 7'h02 || a == 7'h04 || a == 7'h06) return a + 7'h01;
        if (a == 7'h00 && tib) return 7'h01;
        if (a < 7'h02 && me) return 7'h02;
        if (a < 7'h04 && !xdis) return 7'h04;
        if (a < 7'h06 && !ydis) return 7'h06;
        return 7'h08;
    endfunction
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        step();
        i_host.frame({1'b0, a}, 1, d);
    endtask
    // burst read up to max bytes, stopping after 08h unless fast read wraps on
    task automatic burst(input logic [6:0] a0, input int max);
        logic [6:0] a;
        int n;
        a = a0;
        n = 0;
        while (n < max) begin
            exp_q.push_back(val(a));
            n++;
            if (a == ADDR_PAST_Y && !fr) break;
            a = nxt(a);
        end
        step();
        i_host.frame({1'b1, a0}, n, 8'h00);
    endtask
    task automatic new_sample();
        logic [31:0] r;
        r = rnd();
        step();
        temp = r[7:0];
        mag = r[19:8];
        xd = r[31:20];
        r = rnd();
        yd = r[11:0];
        flags = r[19:12];
        sample_valid = 1'b1;
        flags_valid = 1'b1;
        step();
        sample_valid = 1'b0;
        flags_valid = 1'b0;
    endtask
    task automatic boot_check();
        int n;
        n = 0;
        while (boot_pulse !== 1'b1 && n < 200) begin
            step();
            n++;
        end
        n = 0;
        while (boot_pulse === 1'b1) begin
            step();
            n++;
        end
        chk("boot_pulse", 12'(n), 12'(BPC));
        chk("mode", {10'h000, active, deep_sleep}, 12'h000);
    endtask
    // monitor: every read byte retires the oldest expected byte
    initial forever begin
        @(posedge rd_strobe);
        if (exp_q.size() == 0) begin
            chk("read_extra", 12'h001, 12'h000);
        end else begin
            chk("read_byte", {4'h0, rd_byte}, {4'h0, exp_q.pop_front()});
        end
    end
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 80000) begin
            failures++;
            wrap_up();
        end
    end
    // main sequence
    initial begin
        sys_rst = 1'b1;
        sample_valid = 1'b0;
        flags_valid = 1'b0;
        {temp, mag, xd, yd} = '0;
        flags = EVENT_FLAGS_RST;
        {bo, tib, fr, me, xdis, ydis} = 6'h00;
        seed = 32'h00000053;
        repeat (4) @(posedge clk_sys);
        #2 sys_rst = 1'b0;
        boot_check();
        burst(ADDR_EVENT_FLAGS, 1);
        // every skip and byte order setting, each from start address c % 8 only
        for (int c = 0; c < 32; c++) begin
            {ydis, xdis, me, tib, bo} = 5'(c);
            new_sample();
            wr(ADDR_CFG_B, {6'h00, tib, bo});
            wr(ADDR_CFG_E, {4'h0, ydis, xdis, me, 1'b0});
            wr(7'(c % 8), 8'(rnd()));
            burst(7'(c % 8), 9);
        end
        // fast read wraps 04, 06, 08, 00 then normal stepping
        {ydis, xdis, me, tib, bo, fr} = 6'h01;
        wr(ADDR_CFG_E, 8'h00);
        wr(ADDR_CFG_B, 8'h04);
        burst(ADDR_X_FIRST, 6);
        wr(ADDR_CFG_A, 8'h01);
        chk("active_on", {11'h000, active}, 12'h001);
        wr(ADDR_CFG_A, 8'h00);
        chk("active_off", {11'h000, active}, 12'h000);
        wr(ADDR_CFG_E, 8'h01);
        repeat (20) step();
        chk("sleep_early", {11'h000, deep_sleep}, 12'h000);
        repeat (25) step();
        chk("sleep", {11'h000, deep_sleep}, 12'h001);
        i_host.wake(50);
        repeat (20) step();
        chk("glitch", {11'h000, deep_sleep}, 12'h001);
        i_host.wake(400);
        boot_check();
        // configuration must come back cleared after the wake boot
        fr = 1'b0;
        new_sample();
        burst(ADDR_EVENT_FLAGS, 9);
        repeat (10) step();
        chk("queue_left", 12'(exp_q.size()), 12'h000);
        wrap_up();
    end
endmodule
`default_nettype wire
